// ### pudc_pkg.sv
// Package: constants and types for the presettable up/down counter
`default_nettype none
package pudc_pkg;
    localparam int unsigned CNT_W         = 4;
    localparam logic [3:0]  CNT_RST_VAL   = 4'h0;
    localparam logic [3:0]  CNT_MIN       = 4'h0;
    localparam logic [3:0]  CNT_MAX_BCD   = 4'h9;
    localparam logic [3:0]  CNT_MAX_BIN   = 4'hF;
    localparam int unsigned SYNC_STAGES   = 2;

    typedef enum logic [1:0] {
        PUDC_IDLE = 2'b00,
        PUDC_UP   = 2'b01,
        PUDC_DOWN = 2'b10
    } pudc_dir_t;
endpackage : pudc_pkg
`default_nettype wire

// ### pudc_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pudc_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock, reset and enable
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             en_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else if (en_i) begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : pudc_sync
`default_nettype wire

// ### pudc_counter.sv
// Presettable up/down counter with cascade carry and borrow outputs
`timescale 1ns/1ps
`default_nettype none
//  Function
//  - Count held in four flip-flops, shown on outputs with carry and borrow.
//  - Reset input high forces count low, overriding everything else.
//  - Load control low copies preset inputs into the count.
//  - Up strobe rising edge increments while down strobe is high.
//  - Down strobe rising edge decrements while up strobe is high.
//  - Carry and borrow stay high when no terminal count is signalled.
//  - At maximum while counting up, carry low while up strobe low.
//  - At minimum while counting down, borrow low while down strobe low.
module pudc_counter
    import pudc_pkg::*;
#(
    parameter bit DECIMAL = 1'b0
) (
    // Clock, reset and enable
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    input  wire logic                       en_i,
    // Control pins
    input  wire logic                       reset_i,
    input  wire logic                       load_control_low_i,
    input  wire logic                       count_up_i,
    input  wire logic                       count_down_i,
    // Preset inputs
    input  wire logic                       preset_input_bit0_i,
    input  wire logic                       preset_input_bit1_i,
    input  wire logic                       preset_input_bit2_i,
    input  wire logic                       preset_input_bit3_i,
    // Count and cascade outputs
    output logic                            count_out_bit0_o,
    output logic                            count_out_bit1_o,
    output logic                            count_out_bit2_o,
    output logic                            count_out_bit3_o,
    output logic                            carry_low_o,
    output logic                            borrow_low_o
);
    import pudc_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic       rst_s;
    logic       load_n_s;
    logic       up_s;
    logic       dn_s;
    logic [3:0] preset_s;

    assign pins_raw = {preset_input_bit3_i, preset_input_bit2_i,
                       preset_input_bit1_i, preset_input_bit0_i,
                       count_down_i, count_up_i,
                       load_control_low_i, reset_i};

    // Idle strobes and load are high, reset held active until seen
    pudc_sync #(
        .WIDTH   (8),
        .RST_VAL (8'h0F)
    ) u_sync (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .en_i    (en_i),
        .d_i     (pins_raw),
        .q_o     (pins_s)
    );

    assign rst_s    = pins_s[0];
    assign load_n_s = pins_s[1];
    assign up_s     = pins_s[2];
    assign dn_s     = pins_s[3];
    assign preset_s = pins_s[7:4];

    // ----------------------------------------------------------------
    // Edge detection and direction
    // ----------------------------------------------------------------
    logic      up_q;
    logic      dn_q;
    logic      up_rise;
    logic      dn_rise;
    pudc_dir_t dir_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_max;

    assign cnt_max = DECIMAL ? CNT_MAX_BCD : CNT_MAX_BIN;
    assign up_rise = up_s & ~up_q & dn_s;
    assign dn_rise = dn_s & ~dn_q & up_s;

    // Idle level is high, so no false edge follows reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_q <= 1'b1;
        end else if (en_i) begin
            up_q <= up_s;
        end
    end

    // Same for the down strobe
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dn_q <= 1'b1;
        end else if (en_i) begin
            dn_q <= dn_s;
        end
    end

    // Wrap helpers; an illegal BCD code 10..15 steps on to zero
    function automatic logic [3:0] step_up(input logic [3:0] v,
                                           input logic [3:0] mx);
        step_up = (v >= mx) ? CNT_MIN : 4'(v + 4'h1);
    endfunction : step_up

    function automatic logic [3:0] step_dn(input logic [3:0] v,
                                           input logic [3:0] mx);
        step_dn = (v == CNT_MIN) ? mx : 4'(v - 4'h1);
    endfunction : step_dn

    // ----------------------------------------------------------------
    // Count register
    // ----------------------------------------------------------------
    // Reset and load act after two sync edges, not truly asynchronously;
    // the trade buys glitch-free pins at the cost of latency
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= CNT_RST_VAL;
        end else if (en_i) begin
            if (rst_s) begin
                cnt_q <= CNT_RST_VAL;
            end else if (!load_n_s) begin
                cnt_q <= preset_s;
            end else if (up_rise) begin
                cnt_q <= step_up(cnt_q, cnt_max);
            end else if (dn_rise) begin
                cnt_q <= step_dn(cnt_q, cnt_max);
            end
        end
    end

    // Last counting direction; reset and load clear it
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dir_q <= PUDC_IDLE;
        end else if (en_i) begin
            if (rst_s || !load_n_s) begin
                dir_q <= PUDC_IDLE;
            end else if (up_rise) begin
                dir_q <= PUDC_UP;
            end else if (dn_rise) begin
                dir_q <= PUDC_DOWN;
            end
        end
    end

    // ----------------------------------------------------------------
    // Cascade outputs
    // ----------------------------------------------------------------
    // Terminal flag follows the low half of the strobe, so the next
    // stage sees its rising edge as the strobe returns high
    function automatic logic term_low(input logic [3:0] v,
                                      input logic [3:0] bound,
                                      input logic       strobe_s,
                                      input logic       rst,
                                      input logic       load_n);
        // Pending reset or load masks the flag of a cleared stage
        term_low = (v == bound) & ~strobe_s & ~rst & load_n;
    endfunction : term_low

    logic carry_hit;
    logic borrow_hit;

    assign carry_hit  = term_low(cnt_q, cnt_max, up_s, rst_s, load_n_s);
    assign borrow_hit = term_low(cnt_q, CNT_MIN, dn_s, rst_s, load_n_s);

    // Carry only in up mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            carry_low_o <= 1'b1;
        end else if (en_i) begin
            case (dir_q)
                PUDC_UP: begin
                    carry_low_o <= ~carry_hit;
                end
                PUDC_DOWN: begin
                    carry_low_o <= 1'b1;
                end
                default: begin
                    carry_low_o <= 1'b1;
                end
            endcase
        end
    end

    // Borrow only in down mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            borrow_low_o <= 1'b1;
        end else if (en_i) begin
            case (dir_q)
                PUDC_UP: begin
                    borrow_low_o <= 1'b1;
                end
                PUDC_DOWN: begin
                    borrow_low_o <= ~borrow_hit;
                end
                default: begin
                    borrow_low_o <= 1'b1;
                end
            endcase
        end
    end

    assign count_out_bit0_o = cnt_q[0];
    assign count_out_bit1_o = cnt_q[1];
    assign count_out_bit2_o = cnt_q[2];
    assign count_out_bit3_o = cnt_q[3];
endmodule : pudc_counter
`default_nettype wire

// ### pudc_counter_assertions.sv
// Pin-level checks for the presettable up/down counter
`timescale 1ns/1ps
`default_nettype none
module pudc_counter_sva
    import pudc_pkg::*;
#(parameter bit DECIMAL = 1'b0) (
    input wire logic clk_i, rstn_i, en_i, reset_i, load_control_low_i,
    input wire logic count_up_i, count_down_i, carry_low_o, borrow_low_o,
    input wire logic preset_input_bit0_i, preset_input_bit1_i,
    input wire logic preset_input_bit2_i, preset_input_bit3_i,
    input wire logic count_out_bit0_o, count_out_bit1_o,
    input wire logic count_out_bit2_o, count_out_bit3_o
);
    logic [3:0] mx, c, p, inc, dec;
    logic       run;
    assign mx = DECIMAL ? CNT_MAX_BCD : CNT_MAX_BIN;
    assign c = {count_out_bit3_o, count_out_bit2_o,
                count_out_bit1_o, count_out_bit0_o};
    assign p = {preset_input_bit3_i, preset_input_bit2_i,
                preset_input_bit1_i, preset_input_bit0_i};
    // Codes above the top value also step to zero
    assign inc = (c >= mx) ? CNT_MIN : c + 4'h1;
    assign dec = (c == CNT_MIN) ? mx : c - 4'h1;
    assign run = en_i && !reset_i && load_control_low_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    reset_clr_a: assert property ((en_i && reset_i)[*3] |=>
        c == CNT_RST_VAL && carry_low_o && borrow_low_o) else $error("no clear");
    load_copy_a: assert property ((en_i && !reset_i && !load_control_low_i
        && $stable(p))[*3] |=> c == p) else $error("preset not copied");
    up_step_a: assert property ((run && count_down_i && !count_up_i)[*3]
        ##1 (run && count_down_i && count_up_i)[*5] |-> c == $past(inc, 5))
        else $error("up step wrong");
    down_step_a: assert property ((run && count_up_i && !count_down_i)[*3]
        ##1 (run && count_up_i && count_down_i)[*5] |-> c == $past(dec, 5))
        else $error("down step wrong");
    carry_max_a: assert property ($fell(carry_low_o) |-> c == mx)
        else $error("carry off max");
    borrow_min_a: assert property ($fell(borrow_low_o) |-> c == CNT_MIN)
        else $error("borrow off min");
    flags_excl_a: assert property (carry_low_o || borrow_low_o)
        else $error("both flags low");
    hold_still_a: assert property ((run && $stable(count_up_i)
        && $stable(count_down_i))[*5] |=> $stable(c)) else $error("count drift");
endmodule : pudc_counter_sva
bind pudc_counter pudc_counter_sva #(.DECIMAL(DECIMAL)) i_sva (.*);
`default_nettype wire

// ### pudc_stage_drv.sv
// Strobe source standing in for the preceding cascade stage
`timescale 1ns/1ps
`default_nettype none
module pudc_stage_drv #(parameter int LEN = 5) (
    input  wire logic clk_i,
    output var  logic up_o,
    output var  logic dn_o
);
    // Idle high, as a carry or borrow output between terminal counts
    initial begin
        up_o = 1'b1;
        dn_o = 1'b1;
    end
    task automatic strobe(input bit up, input logic v);
        @(negedge clk_i);
        if (up) up_o = v;
        else dn_o = v;
        repeat (LEN - 1) @(negedge clk_i);
    endtask : strobe
    task automatic pulse(input bit up, input int n);
        repeat (n) begin
            strobe(up, 1'b0);
            strobe(up, 1'b1);
        end
    endtask : pulse
endmodule : pudc_stage_drv
`default_nettype wire

// ### pudc_counter_test.sv
// Self-checking bench for the presettable up/down counter
`timescale 1ns/1ps
`default_nettype none
module pudc_counter_test;
    import pudc_pkg::*;
    logic       clk_i = 1'b0, rstn_i = 1'b0, reset_i = 1'b0, load_n = 1'b1;
    logic [3:0] pre = 4'h0;
    wire logic  up, dn, carry_n, borrow_n;
    wire logic [3:0] q, q_b;
    wire logic  carry_b, borrow_b;
    int         num_errors = 0, comparisons = 0;
    pudc_stage_drv i_drv (.clk_i(clk_i), .up_o(up), .dn_o(dn));
    pudc_counter #(.DECIMAL(1'b1)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .en_i(1'b1), .reset_i(reset_i), .load_control_low_i(load_n),
        .count_up_i(up), .count_down_i(dn), .preset_input_bit0_i(pre[0]),
        .preset_input_bit1_i(pre[1]), .preset_input_bit2_i(pre[2]),
        .preset_input_bit3_i(pre[3]), .count_out_bit0_o(q[0]),
        .count_out_bit1_o(q[1]), .count_out_bit2_o(q[2]),
        .count_out_bit3_o(q[3]), .carry_low_o(carry_n),
        .borrow_low_o(borrow_n));
    pudc_counter #(.DECIMAL(1'b0)) i_dut_bin (.clk_i(clk_i), .rstn_i(rstn_i),
        .en_i(1'b1), .reset_i(reset_i), .load_control_low_i(load_n),
        .count_up_i(up), .count_down_i(dn), .preset_input_bit0_i(pre[0]),
        .preset_input_bit1_i(pre[1]), .preset_input_bit2_i(pre[2]),
        .preset_input_bit3_i(pre[3]), .count_out_bit0_o(q_b[0]),
        .count_out_bit1_o(q_b[1]), .count_out_bit2_o(q_b[2]),
        .count_out_bit3_o(q_b[3]), .carry_low_o(carry_b),
        .borrow_low_o(borrow_b));
    initial forever #20 clk_i = ~clk_i;
    task automatic check(input string what, input logic [3:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Pins act three edges after a change, so waits are fixed
    task automatic load(input logic [3:0] v);
        @(negedge clk_i);
        pre = v;
        load_n = 1'b0;
        repeat (4) @(negedge clk_i);
        load_n = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask : load
    task automatic t_up;
        load(4'h7);
        i_drv.pulse(1'b1, 2);
        check("count up", q, CNT_MAX_BCD);
        check("carry idle", carry_n, 1'b1);
        i_drv.strobe(1'b1, 1'b0);
        check("carry", carry_n, 1'b0);
        i_drv.strobe(1'b1, 1'b1);
        check("wrap up", q, CNT_MIN);
        check("carry back", carry_n, 1'b1);
    endtask : t_up
    task automatic t_reset;
        load(4'h5);
        reset_i = 1'b1;
        i_drv.pulse(1'b1, 1);
        check("reset", q, CNT_RST_VAL);
        load_n = 1'b0;
        pre = 4'h3;
        i_drv.pulse(1'b0, 1);
        check("reset over load", q, CNT_RST_VAL);
        reset_i = 1'b0;
        i_drv.pulse(1'b1, 1);
        check("load over count", q, 4'h3);
        load_n = 1'b1;
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
    endtask : t_reset
    task automatic t_down;
        load(4'h1);
        i_drv.pulse(1'b0, 1);
        check("count down", q, CNT_MIN);
        i_drv.strobe(1'b0, 1'b0);
        check("borrow", borrow_n, 1'b0);
        i_drv.pulse(1'b1, 1);
        check("up blocked", q, CNT_MIN);
        i_drv.strobe(1'b0, 1'b1);
        check("wrap down", q, CNT_MAX_BCD);
        check("borrow back", borrow_n, 1'b1);
    endtask : t_down
    task automatic t_bin;
        load(4'hE);
        i_drv.pulse(1'b1, 1);
        check("bin up", q_b, CNT_MAX_BIN);
        i_drv.strobe(1'b1, 1'b0);
        check("bin carry", carry_b, 1'b0);
        i_drv.strobe(1'b1, 1'b1);
        check("bin wrap up", q_b, CNT_MIN);
        i_drv.pulse(1'b0, 1);
        check("bin wrap down", q_b, CNT_MAX_BIN);
        check("bin borrow idle", borrow_b, 1'b1);
    endtask : t_bin
    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    initial begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        for (int v = 0; v < 10; v++) begin
            load(4'(v));
            check("load", q, 4'(v));
        end
        t_up();
        t_reset();
        t_down();
        t_bin();
        results();
    end
endmodule : pudc_counter_test
`default_nettype wire
